//--- hw/tpop_pkg.sv
// Package for the tracking position output port: timing, codes, carriers.
// Assumes a single 100 MHz clock; no other file defines these names.

package tpop_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // Busy width per step; must stay well below the settle time
   localparam int BUSY_TIME_NS = 150;
   localparam int BUSY_CYC = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRAP_TIME_NS = 100;
   localparam int WRAP_CYC = (WRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_TIME_NS = 600;
   localparam int SETTLE_CYC = SETTLE_TIME_NS / CLK_PERIOD_NS;
   // Input synchroniser depth plus state register
   localparam int PIN_LATENCY = 4;

   // ------------------------------------------------------------------
   // Word and resolution
   // ------------------------------------------------------------------
   localparam int POS_W = 16;
   localparam logic [1:0] RES_10 = 2'h0;
   localparam logic [1:0] RES_12 = 2'h1;
   localparam logic [1:0] RES_14 = 2'h2;
   localparam logic [1:0] RES_16 = 2'h3;
   localparam logic [15:0] POS_ONES = 16'hFFFF;
   localparam logic [15:0] POS_ONE = 16'h0001;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CLEAR = 8'h04;
   localparam logic [7:0] REG_ENABLE = 8'h08;
   localparam logic [7:0] REG_POSITION = 8'h0C;
   localparam logic [7:0] REG_PINS = 8'h10;
   localparam int EV_W = 3;
   localparam int EV_STEP = 0;
   localparam int EV_WRAP = 1;
   localparam int EV_REVERSE = 2;

   // ------------------------------------------------------------------
   // Carriers and states
   // ------------------------------------------------------------------
   typedef struct packed {
      logic step_down;
      logic step_up;
      logic [1:0] res_sel;
      logic byte_select;
      logic output_enable_n;
      logic latch_freeze_n;
      logic pin_dir;
   } tpop_pins_t;

   localparam tpop_pins_t PINS_RESET = '{step_down: 1'b0, step_up: 1'b0,
      res_sel: RES_16, byte_select: 1'b0, output_enable_n: 1'b1,
      latch_freeze_n: 1'b1, pin_dir: 1'b0};

   typedef enum logic [1:0] {
      FRZ_FOLLOW = 2'h0,
      FRZ_WAIT = 2'h1,
      FRZ_HOLD = 2'h3
   } tpop_frz_t;

   // Unused low bits per resolution code
   function automatic logic [3:0] res_shift(input logic [1:0] code);
      logic [3:0] s;
      s = 4'h0;
      unique case (code)
         RES_10: s = 4'h6;
         RES_12: s = 4'h4;
         RES_14: s = 4'h2;
         RES_16: s = 4'h0;
      endcase
      return s;
   endfunction : res_shift

endpackage : tpop_pkg

//--- hw/tpop_core.sv
// Tracking position output port: counter, busy, wrap, latches, byte bus.
// Assumes step pulses and host pins arrive asynchronous to clock.
//
// Contract
// RQ1 - Count follows each single LSB input step
// RQ2 - One busy pulse per count step
// RQ3 - Busy high while count is changing
// RQ4 - Enable high floats the data pins
// RQ5 - Enable low drives latch contents onto pins
// RQ6 - Byte select picks high or low byte
// RQ7 - Freeze low stops latch updates
// RQ8 - Pin direction low makes pins inputs
// RQ9 - Direction output shows rotation sense
// RQ10 - Wrap pulse on all-ones/all-zeros crossing
// RQ11 - Select inputs set 10/12/14/16 bit width
// RQ12 - Host changes resolution only while not busy
// RQ13 - Counter tracks every step without commands
// RQ14 - Latched data stable within 600 ns
// RQ15 - Direction latched, valid before wrap pulse
// RQ16 - Wrap and direction ignore freeze
// RQ17 - Unused low bits zero, fixed select map
// RQ18 - Host holds freeze through both byte reads
//
// Local design decisions: the placing of the registers and the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module tpop_core #(
   parameter int BUSY_CYCLES = tpop_pkg::BUSY_CYC,
   parameter int WRAP_CYCLES = tpop_pkg::WRAP_CYC,
   parameter int SETTLE_CYCLES = tpop_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Step pulses from the tracking loop
   input wire logic step_up,
   input wire logic step_down,
   // Host control pins
   input wire logic resolution_select_a,
   input wire logic resolution_select_b,
   input wire logic byte_select,
   input wire logic output_enable_n,
   input wire logic latch_freeze_n,
   input wire logic pin_dir,
   // Status pins
   output logic busy,
   output logic direction,
   output logic turn_wrap_pulse,
   // Data pins
   input wire logic [15:0] position_pins_in,
   output logic [15:0] position_pins_out,
   output logic [15:0] position_pins_oe_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic irq
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // Filter, state change and pin register all eat into the settle time
   localparam int DEADLINE = SETTLE_CYCLES - tpop_pkg::PIN_LATENCY - 3;
   if (BUSY_CYCLES < 1 || BUSY_CYCLES >= DEADLINE || BUSY_CYCLES > 255)
   begin : g_bad_busy
      $error("busy width must be 1..255 and below the settle time");
   end
   if (WRAP_CYCLES < 1 || WRAP_CYCLES > 255)
   begin : g_bad_wrap
      $error("wrap width must be 1..255");
   end
   if (DEADLINE < 2 || DEADLINE > 255)
   begin : g_bad_settle
      $error("settle time out of range");
   end

   localparam int PW = $bits(tpop_pkg::tpop_pins_t);
   localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYCLES);
   localparam logic [7:0] WRAP_LOAD = 8'(WRAP_CYCLES);
   localparam logic [7:0] WAIT_LIMIT = 8'(DEADLINE);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // A bit changes only once stages two and three agree, so a glitch
   // shorter than a clock never reaches the counter.
   tpop_pkg::tpop_pins_t raw;
   tpop_pkg::tpop_pins_t filt;
   tpop_pkg::tpop_pins_t filt_d;
   logic [PW-1:0] sync_s1;
   logic [PW-1:0] sync_s2;
   logic [PW-1:0] sync_s3;
   logic [PW-1:0] next_filt;

   assign raw = '{step_down: step_down, step_up: step_up,
      res_sel: {resolution_select_b, resolution_select_a},
      byte_select: byte_select, output_enable_n: output_enable_n,
      latch_freeze_n: latch_freeze_n, pin_dir: pin_dir};

   for (genvar i = 0; i < PW; i++)
   begin : g_filt
      assign next_filt[i] = (sync_s2[i] & sync_s3[i]) |
         (filt[i] & (sync_s2[i] | sync_s3[i]));
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sync_s1 <= tpop_pkg::PINS_RESET;
         sync_s2 <= tpop_pkg::PINS_RESET;
         sync_s3 <= tpop_pkg::PINS_RESET;
         filt <= tpop_pkg::PINS_RESET;
         filt_d <= tpop_pkg::PINS_RESET;
      end
      else
      begin
         sync_s1 <= raw;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
         filt <= next_filt;
         filt_d <= filt;
      end
   end

   // ------------------------------------------------------------------
   // Position counter
   // ------------------------------------------------------------------
   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] pos_mask;
   logic [15:0] pos_step;
   logic [3:0] shift;
   logic up_edge;
   logic down_edge;
   logic up_evt;
   logic down_evt;
   logic wrap_evt;
   logic reverse_evt;

   assign up_edge = filt.step_up & ~filt_d.step_up;
   assign down_edge = filt.step_down & ~filt_d.step_down;
   // Opposite steps in one cycle cancel out
   assign up_evt = up_edge & ~down_edge; // [RQ1] [RQ13]
   assign down_evt = down_edge & ~up_edge; // [RQ1] [RQ13]
   assign shift = tpop_pkg::res_shift(filt.res_sel); // [RQ11] [RQ17]
   assign pos_mask = tpop_pkg::POS_ONES << shift; // [RQ17]
   assign pos_step = tpop_pkg::POS_ONE << shift; // [RQ11]
   // Changing resolution mid-step is the host's hazard; mask re-applies
   assign next_count = up_evt ? ((count + pos_step) & pos_mask) :
      down_evt ? ((count - pos_step) & pos_mask) :
      (count & pos_mask); // [RQ1] [RQ12] [RQ17]
   assign wrap_evt = (up_evt & ((count | ~pos_mask) == tpop_pkg::POS_ONES)) |
      (down_evt & ((count & pos_mask) == '0)); // [RQ10]
   assign reverse_evt = (up_evt & ~direction) | (down_evt & direction);

   logic wrap_evt_d;
   logic [7:0] busy_cnt;
   logic [7:0] next_busy_cnt;
   logic [7:0] wrap_cnt;
   logic [7:0] next_wrap_cnt;

   assign next_busy_cnt = (up_evt | down_evt) ? BUSY_LOAD :
      (busy_cnt != '0) ? busy_cnt - 8'h01 : busy_cnt; // [RQ2] [RQ3]
   // Wrap trails direction by a cycle so direction is always settled
   assign next_wrap_cnt = wrap_evt_d ? WRAP_LOAD :
      (wrap_cnt != '0) ? wrap_cnt - 8'h01 : wrap_cnt; // [RQ15]

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         direction <= 1'b1;
         busy_cnt <= '0;
         busy <= 1'b0;
         wrap_evt_d <= 1'b0;
         wrap_cnt <= '0;
         turn_wrap_pulse <= 1'b0;
      end
      else
      begin
         count <= next_count; // [RQ1]
         direction <= up_evt ? 1'b1 : down_evt ? 1'b0 : direction; // [RQ9] [RQ15] [RQ16]
         busy_cnt <= next_busy_cnt;
         busy <= next_busy_cnt != '0; // [RQ2] [RQ3]
         wrap_evt_d <= wrap_evt;
         wrap_cnt <= next_wrap_cnt;
         turn_wrap_pulse <= next_wrap_cnt != '0; // [RQ10] [RQ16]
      end
   end

   // ------------------------------------------------------------------
   // Output latch freeze
   // ------------------------------------------------------------------
   // A pending busy may finish first; the deadline keeps data ready
   // inside the settle time even under continuous stepping.
   tpop_pkg::tpop_frz_t frz;
   tpop_pkg::tpop_frz_t next_frz;
   logic [7:0] wait_cnt;
   logic [15:0] out_latch;
   logic freeze_req;
   logic load_latch;

   assign freeze_req = ~filt.latch_freeze_n; // [RQ7]
   assign load_latch = (frz != tpop_pkg::FRZ_HOLD) & ~busy; // [RQ3] [RQ7]

   always_comb
   begin
      next_frz = frz;
      unique case (frz)
         tpop_pkg::FRZ_FOLLOW:
            if (freeze_req)
               next_frz = busy ? tpop_pkg::FRZ_WAIT : tpop_pkg::FRZ_HOLD;
         tpop_pkg::FRZ_WAIT:
            if (!freeze_req)
               next_frz = tpop_pkg::FRZ_FOLLOW;
            else if (!busy || wait_cnt == WAIT_LIMIT)
               next_frz = tpop_pkg::FRZ_HOLD; // [RQ14]
         tpop_pkg::FRZ_HOLD:
            if (!freeze_req)
               next_frz = tpop_pkg::FRZ_FOLLOW; // [RQ18]
         default:
            next_frz = tpop_pkg::FRZ_FOLLOW;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         frz <= tpop_pkg::FRZ_FOLLOW;
         wait_cnt <= '0;
         out_latch <= '0;
      end
      else
      begin
         frz <= next_frz;
         wait_cnt <= (frz == tpop_pkg::FRZ_WAIT) ? wait_cnt + 8'h01 : 8'h00;
         if (load_latch)
            out_latch <= count; // [RQ7] [RQ14]
      end
   end

   // ------------------------------------------------------------------
   // Data pins
   // ------------------------------------------------------------------
   logic drive;
   logic [7:0] lane_byte;

   // Pins as inputs are only listened to by the register port
   assign drive = ~filt.output_enable_n & filt.pin_dir; // [RQ4] [RQ5] [RQ8]
   assign lane_byte = filt.byte_select ? out_latch[15:8] :
      out_latch[7:0]; // [RQ6]

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         position_pins_out <= '0;
         position_pins_oe_n <= '1;
      end
      else
      begin
         position_pins_out <= {out_latch[15:8], lane_byte}; // [RQ5] [RQ6]
         position_pins_oe_n <= {16{~drive}}; // [RQ4] [RQ8]
      end
   end

   // ------------------------------------------------------------------
   // Register port and interrupt
   // ------------------------------------------------------------------
   logic [tpop_pkg::EV_W-1:0] status;
   logic [tpop_pkg::EV_W-1:0] enable;
   logic [tpop_pkg::EV_W-1:0] events;
   logic [tpop_pkg::EV_W-1:0] clr;
   logic [tpop_pkg::EV_W-1:0] next_status;
   logic [tpop_pkg::EV_W-1:0] next_enable;
   logic [31:0] read_mux;
   logic wr_clear;
   logic wr_enable;

   assign events[tpop_pkg::EV_STEP] = up_evt | down_evt;
   assign events[tpop_pkg::EV_WRAP] = wrap_evt;
   assign events[tpop_pkg::EV_REVERSE] = reverse_evt;
   assign wr_clear = reg_write & (reg_addr == tpop_pkg::REG_CLEAR);
   assign wr_enable = reg_write & (reg_addr == tpop_pkg::REG_ENABLE);
   assign clr = wr_clear ? reg_wdata[tpop_pkg::EV_W-1:0] : '0;
   // Set beats clear so no event is lost
   assign next_status = (status & ~clr) | events;
   assign next_enable = wr_enable ? reg_wdata[tpop_pkg::EV_W-1:0] : enable;

   always_comb
   begin
      read_mux = '0;
      unique case (reg_addr)
         tpop_pkg::REG_STATUS: read_mux = {29'h0, status};
         tpop_pkg::REG_ENABLE: read_mux = {29'h0, enable};
         tpop_pkg::REG_POSITION: read_mux = {out_latch, count};
         tpop_pkg::REG_PINS: read_mux = {position_pins_in, 4'h0,
            frz == tpop_pkg::FRZ_HOLD, busy, direction, filt.res_sel,
            filt.byte_select, filt.output_enable_n,
            filt.latch_freeze_n, filt.pin_dir, shift[2:1], 1'b0};
         default: read_mux = '0;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         status <= '0;
         enable <= '0;
         irq <= 1'b0;
         reg_rdata <= '0;
      end
      else
      begin
         status <= next_status;
         enable <= next_enable;
         irq <= |(next_status & next_enable);
         reg_rdata <= reg_read ? read_mux : 32'h0;
      end
   end

endmodule : tpop_core

`default_nettype wire

//--- testbench/tpop_core_asserts.sv
// Checker for the position output port, watching core ports only.
// Assumes the core keeps its default busy, wrap and settle counts.
`timescale 1ns/1ps
`default_nettype none
module tpop_core_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Host pins
   input wire logic output_enable_n,
   input wire logic latch_freeze_n,
   input wire logic pin_dir,
   // Device outputs
   input wire logic busy,
   input wire logic direction,
   input wire logic turn_wrap_pulse,
   input wire logic [15:0] position_pins_out,
   input wire logic [15:0] position_pins_oe_n
);
   // ------------------------------------------------------------
   // Freeze age, saturating so long holds stay checked
   // ------------------------------------------------------------
   logic [6:0] frz_age;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         frz_age <= 7'h00;
      else if (latch_freeze_n)
         frz_age <= 7'h00;
      else if (frz_age != 7'h7F)
         frz_age <= frz_age + 7'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_wrap_on;
      turn_wrap_pulse[*8] ##1 turn_wrap_pulse[*2];
   endsequence
   property p_busy_len; $rose(busy) |-> busy[*8]; endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("Busy pulse short");
   property p_wrap_len; $rose(turn_wrap_pulse) |-> s_wrap_on ##1 !turn_wrap_pulse;
   endproperty
   a_wrap_len: assert property (p_wrap_len)
      else $error("Wrap pulse width wrong");
   property p_dir_wrap; $rose(turn_wrap_pulse) |-> $stable(direction); endproperty
   a_dir_wrap: assert property (p_dir_wrap)
      else $error("Direction moved at wrap");
   property p_dir_busy; $changed(direction) |-> busy; endproperty
   a_dir_busy: assert property (p_dir_busy)
      else $error("Direction moved without a step");
   property p_float; output_enable_n[*8] |-> position_pins_oe_n == 16'hFFFF;
   endproperty
   a_float: assert property (p_float)
      else $error("Pins driven while disabled");
   property p_input; (!pin_dir)[*8] |-> position_pins_oe_n == 16'hFFFF; endproperty
   a_input: assert property (p_input)
      else $error("Pins driven while inputs");
   property p_drive;
      (!output_enable_n && pin_dir)[*8] |-> position_pins_oe_n == 16'h0000;
   endproperty
   a_drive: assert property (p_drive)
      else $error("Pins not driven");
   property p_frozen; frz_age > 7'h3F |-> $stable(position_pins_out[15:8]);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("Frozen word moved");
endmodule : tpop_core_asserts
bind tpop_core tpop_core_asserts u_asserts (.clock, .rst, .output_enable_n,
   .latch_freeze_n, .pin_dir, .busy, .direction, .turn_wrap_pulse,
   .position_pins_out, .position_pins_oe_n);
`default_nettype wire

//--- testbench/tpop_host_model.sv
// Host processor model: freezes the latch and reads two bytes.
// Assumes the bench resolves the shared pins and pulses start.
`timescale 1ns/1ps
`default_nettype none
module tpop_host_model (
   // Clock and command
   input wire logic clock,
   input wire logic start,
   output logic done,
   output logic [15:0] word,
   output logic [7:0] upper_lane,
   // Device pins
   input wire logic [15:0] pins,
   output logic latch_freeze_n,
   output logic byte_select,
   output logic output_enable_n,
   output logic pin_dir,
   output logic [15:0] pins_drive
);
   initial
   begin
      {latch_freeze_n, output_enable_n, byte_select, pin_dir, done} = 5'h18;
      pins_drive = 16'h0000;
   end
   // Released lines never hold a stale value
   always @(posedge clock)
      pins_drive <= pins_drive + 16'h1357;
   always
   begin
      @(posedge clock);
      if (start)
      begin
         latch_freeze_n <= 1'b0;
         output_enable_n <= 1'b0;
         pin_dir <= 1'b1;
         byte_select <= 1'b1;
         repeat (62) @(posedge clock);
         word[15:8] <= pins[7:0];
         upper_lane <= pins[15:8];
         byte_select <= 1'b0;
         repeat (7) @(posedge clock);
         word[7:0] <= pins[7:0];
         latch_freeze_n <= 1'b1;
         output_enable_n <= 1'b1;
         pin_dir <= 1'b0;
         done <= 1'b1;
         @(posedge clock);
         done <= 1'b0;
      end
   end
endmodule : tpop_host_model
`default_nettype wire

//--- testbench/tpop_core_tb.sv
// Bench for the position output port: steps, irq and host byte reads.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tpop_core_tb;
   logic clock, rst, step_up, step_down, res_a, res_b, start, done, wrap;
   logic reg_write, reg_read, busy, direction, irq, frz_n, bsel, oe_n, pdir;
   logic [7:0] reg_addr, upper_lane;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [15:0] pins_out, pins_oe_n, pin_wire, float_pat, host_word, exp_cnt;
   logic [1:0] res;
   logic [31:0] seed = 32'h00000044;
   logic [31:0] wrap_cnt = 32'h0;
   logic wrap_d = 1'b0;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   assign pin_wire = (pins_out & ~pins_oe_n) | (float_pat & pins_oe_n);
   tpop_core u_dut (.clock(clock), .rst(rst), .step_up(step_up),
      .step_down(step_down), .resolution_select_a(res_a),
      .resolution_select_b(res_b), .byte_select(bsel),
      .output_enable_n(oe_n), .latch_freeze_n(frz_n), .pin_dir(pdir),
      .busy(busy), .direction(direction), .turn_wrap_pulse(wrap),
      .position_pins_in(pin_wire), .position_pins_out(pins_out),
      .position_pins_oe_n(pins_oe_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .irq(irq));
   tpop_host_model u_host (.clock(clock), .start(start), .done(done),
      .word(host_word), .upper_lane(upper_lane), .pins(pin_wire),
      .latch_freeze_n(frz_n), .byte_select(bsel), .output_enable_n(oe_n),
      .pin_dir(pdir), .pins_drive(float_pat));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Count step per select code; its low bits never move
   function automatic logic [15:0] f_step(input logic [1:0] c);
      return 16'h0040 >> {c, 1'b0};
   endfunction : f_step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
      @(posedge clock);
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rdc
   task automatic step(input logic up);
      logic [31:0] w0;
      logic wr_exp;
      w0 = wrap_cnt;
      wr_exp = up ? (exp_cnt == ~(f_step(res) - 16'h1)) : (exp_cnt == 16'h0);
      exp_cnt = up ? exp_cnt + f_step(res) : exp_cnt - f_step(res);
      step_up <= up;
      step_down <= !up;
      repeat (3) @(posedge clock);
      step_up <= 1'b0;
      step_down <= 1'b0;
      repeat (9) @(posedge clock);
      chk(wrap_cnt - w0, {31'h0, wr_exp});
      chk({31'h0, direction}, {31'h0, up});
      chk({31'h0, busy}, 32'h1);
   endtask : step
   task automatic set_res(input logic [1:0] c);
      for (int i = 0; i < 40 && busy !== 1'b0; i++)
         @(posedge clock);
      res_b <= c[1];
      res_a <= c[0];
      res = c;
      exp_cnt = exp_cnt & ~(f_step(c) - 16'h1);
      repeat (8) @(posedge clock);
   endtask : set_res
   task automatic host_read;
      logic [15:0] snap;
      snap = exp_cnt;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (20) @(posedge clock);
      seed = xs(seed);
      step(seed[0]);
      for (int i = 0; i < 150 && done !== 1'b1; i++)
         @(posedge clock);
      chk({16'h0, host_word}, {16'h0, snap});
      chk({24'h0, upper_lane}, {24'h0, snap[15:8]});
      repeat (25) @(posedge clock);
      rdc(tpop_pkg::REG_POSITION, {exp_cnt, exp_cnt});
   endtask : host_read
   task wrap_up;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // ------------------------------------------------------------
   // Clock, wrap counter, hang guard and main sequence
   // ------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      wrap_d <= wrap;
      if (wrap && !wrap_d)
         wrap_cnt <= wrap_cnt + 32'h1;
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   initial
   begin
      rst = 1'b1;
      {step_up, step_down, reg_write, reg_read, start} = 5'h00;
      {res_b, res_a} = 2'h3;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      res = 2'h3;
      exp_cnt = 16'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      rdc(8'h14, 32'h0);
      rdc(tpop_pkg::REG_ENABLE, 32'h0);
      rdc(tpop_pkg::REG_POSITION, 32'h0);
      rd(tpop_pkg::REG_PINS, rd_val);
      chk(rd_val & 32'hFFFF, 32'h3B0);
      $display("Test reset values done");
      wr(tpop_pkg::REG_ENABLE, 32'h1);
      step(1'b0);
      chk({31'h0, irq}, 32'h1);
      wr(tpop_pkg::REG_CLEAR, 32'h7);
      chk({31'h0, irq}, 32'h0);
      wr(tpop_pkg::REG_ENABLE, 32'h0);
      step(1'b1);
      chk({31'h0, irq}, 32'h0);
      rd(tpop_pkg::REG_STATUS, rd_val);
      chk(rd_val, 32'h7);
      wr(tpop_pkg::REG_CLEAR, 32'h7);
      $display("Test interrupt done");
      for (int r = 0; r < 4; r++)
      begin
         set_res(r[1:0]);
         rd(tpop_pkg::REG_PINS, rd_val);
         chk(rd_val & 32'h186, {23'h0, r[1:0], 4'h0, 2'(3 - r), 1'b0});
         repeat (6)
         begin
            seed = xs(seed);
            step(seed[0]);
         end
         host_read();
         $display("Test resolution %0d done", r);
      end
      wrap_up();
   end
endmodule : tpop_core_tb
`default_nettype wire
